// *** rtl/vga_seq_consts.svh ***
/*
 * Constants for the status, feature control and sequencer register bank:
 * I/O port addresses, sequencer indices, field positions and reset values.
 * Assumes a 10-bit I/O port address carried to the bank by the host bus.
 */
`ifndef VGA_SEQ_CONSTS_SVH
`define VGA_SEQ_CONSTS_SVH

// i/o ports
`define PORT_STATUS0        10'h3c2
`define PORT_SEQ_INDEX      10'h3c4
`define PORT_SEQ_DATA       10'h3c5
`define PORT_FEATURE_RD     10'h3ca
`define PORT_STATUS1_MONO   10'h3ba
`define PORT_STATUS1_COLOR  10'h3da

// sequencer indices
`define SEQ_IDX_HALT        3'h0
`define SEQ_IDX_CLOCK       3'h1
`define SEQ_IDX_MASK        3'h2
`define SEQ_IDX_FONT        3'h3
`define SEQ_IDX_MEMMODE     3'h4

// halt control fields
`define HALT_ASYNC_BIT      0
`define HALT_SYNC_BIT       1

// clock config fields
`define CLK_EIGHT_DOT_BIT   0
`define CLK_SHIFT_LOAD_BIT  2
`define CLK_DOT_DIV2_BIT    3
`define CLK_SHIFT4_BIT      4
`define CLK_SCREEN_OFF_BIT  5

// font select fields
`define FONT_A_HI_BIT       5
`define FONT_B_HI_BIT       4
`define FONT_A_MID_BIT      3
`define FONT_A_LO_BIT       2
`define FONT_B_MID_BIT      1
`define FONT_B_LO_BIT       0

// feature control fields
`define FC_VSYNC_OR_BIT     3

// status register fields
`define ST0_IRQ_BIT         7
`define ST0_SENSE_BIT       4
`define ST1_DIAG_HI_BIT     5
`define ST1_DIAG_LO_BIT     4
`define ST1_VRETRACE_BIT    3
`define ST1_DISP_OFF_BIT    0

// reset values
`define RST_INDEX           3'h0
`define RST_HALT            2'h3
`define RST_CLOCK           6'h00
`define RST_MASK            4'hf
`define RST_FONT            6'h00
`define RST_FEATURE         1'h0
`define READ_ZERO           8'h00

// dot counts per character
`define DOTS_NINE           4'h9
`define DOTS_EIGHT          4'h8

`endif

// *** rtl/vga_seq_pkg.sv ***
/*
 * Types shared by the register bank and its character clock generator.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package vga_seq_pkg;

  typedef enum logic [2:0] {
    SEQ_RUN      = 3'b001,
    SEQ_HALT_REQ = 3'b010,
    SEQ_HALTED   = 3'b100
  } seq_state_e;

  typedef logic [7:0] io_byte_t;

endpackage : vga_seq_pkg

// *** rtl/seq_cfg_if.sv ***
/*
 * Carrier between the register bank and the character clock generator:
 * configuration from the registers, timing strobes and halt state back.
 * Assumes both ends run on clk_sys.
 */
`timescale 1ns/10ps
`default_nettype none

interface seq_cfg_if;
  logic run_async;
  logic run_sync;
  logic eight_dot;
  logic shift_load;
  logic shift4;
  logic dot_div2;
  logic dot_en;
  logic char_tick;
  logic load_pulse;
  logic halted;

  modport ctl (
    output run_async, run_sync, eight_dot, shift_load, shift4, dot_div2,
    input  dot_en, char_tick, load_pulse, halted
  );

  modport gen (
    input  run_async, run_sync, eight_dot, shift_load, shift4, dot_div2,
    output dot_en, char_tick, load_pulse, halted
  );
endinterface : seq_cfg_if

`default_nettype wire

// *** rtl/char_clock_gen.sv ***
/*
 * Character clock generator: dot enable, character tick and serializer
 * load strobes derived from an incoming dot tick, with both halt modes.
 * Assumes dot_tick is a one-cycle pulse synchronous to clk_sys.
 */
`timescale 1ns/10ps
`default_nettype none
`include "vga_seq_consts.svh"

module char_clock_gen #(
  parameter int CNT_W = 4
) (
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic dot_tick,
  seq_cfg_if.gen    cfg
);
  import vga_seq_pkg::*;

  generate
    if (CNT_W < 4) begin : g_bad_width
      $error("char_clock_gen: CNT_W must hold a count of nine");
    end
  endgenerate

  seq_state_e       state;
  seq_state_e       next_state;
  logic             half;
  logic [CNT_W-1:0] dot_cnt;
  logic [1:0]       load_cnt;
  logic [CNT_W-1:0] last_dot;
  logic [1:0]       load_mask;
  logic             dot_raw;
  logic             char_raw;
  logic             active;

  // async halt gates every strobe in the same cycle, no boundary wait
  assign active   = cfg.run_async && (state != SEQ_HALTED);
  assign dot_raw  = dot_tick && (!cfg.dot_div2 || half);
  assign last_dot = cfg.eight_dot ? CNT_W'(`DOTS_EIGHT - 4'h1)
                                  : CNT_W'(`DOTS_NINE - 4'h1);
  // at or past the end, so a mid-character switch to eight dots cannot wrap the count
  assign char_raw = dot_raw && (dot_cnt >= last_dot);
  assign load_mask = cfg.shift4 ? 2'h3 : (cfg.shift_load ? 2'h1 : 2'h0);

  assign cfg.dot_en     = active && dot_raw;
  assign cfg.char_tick  = active && char_raw;
  assign cfg.load_pulse = active && char_raw && ((load_cnt & load_mask) == 2'h0);
  assign cfg.halted     = !active;

  // sync halt takes effect only at the end of the current character
  always_comb begin
    next_state = state;
    case (state)
      SEQ_RUN: begin
        if (!cfg.run_sync) begin
          next_state = SEQ_HALT_REQ;
        end
      end
      SEQ_HALT_REQ: begin
        if (cfg.run_sync) begin
          next_state = SEQ_RUN;
        end else if (char_raw || !cfg.run_async) begin
          next_state = SEQ_HALTED;
        end
      end
      SEQ_HALTED: begin
        if (cfg.run_sync && cfg.run_async) begin
          next_state = SEQ_RUN;
        end
      end
      default: next_state = SEQ_HALTED;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state <= SEQ_RUN;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst || !active) begin
      half <= 1'b0;
    end else if (dot_tick) begin
      half <= !half;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst || !active) begin
      dot_cnt <= '0;
    end else if (char_raw) begin
      dot_cnt <= '0;
    end else if (dot_raw) begin
      dot_cnt <= dot_cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst || !active) begin
      load_cnt <= 2'h0;
    end else if (char_raw) begin
      load_cnt <= load_cnt + 2'h1;
    end
  end

endmodule : char_clock_gen

`default_nettype wire

// *** rtl/vga_seq_regs.sv ***
/*
 * Host-visible status, feature control and indexed sequencer registers
 * of a display controller, plus the outputs those registers steer.
 * Assumes single-cycle I/O read and write strobes synchronous to clk_sys,
 * a 10-bit port address, and video timing inputs from the CRT logic.
 */
`timescale 1ns/10ps
`default_nettype none
`include "vga_seq_consts.svh"

// Contract
// - status port 0 bit 7 reads the pending vertical retrace interrupt.
// - status port 0 bit 4 returns the monitor sense comparator output.
// - status port 1 bits 5:4 mux pixel bits by colour plane select.
// - status port 1 bit 3 reads 1 during vertical retrace.
// - status port 1 bit 0 reads 1 whenever display is disabled.
// - status 1 and feature write decode at 3BA or 3DA by address select.
// - feature control reads at 3CA, writes at the status 1 port.
// - feature bit 3 ORs vertical display enable into vertical sync output.
// - sequencer registers reached by index at 3C4 and data at 3C5.
// - clearing synchronous halt bit stops the sequencer at a boundary.
// - clearing asynchronous halt bit stops the sequencer at once.
// - screen-off bit blanks video while syncs keep running.
// - shift-four loads serializers every fourth character clock.
// - otherwise shift-load picks every or every second character clock.
// - dot clock bit divides the dot clock by two.
// - character clock spans nine dots, or eight when bit set.
// - plane write mask bits enable host writes per plane.
// - font A block from bits 5,3,2 with interleaved 8K mapping.
// - font B block from bits 4,1,0 with the same mapping.
// - with extended memory, attribute bit 3 picks font A or B.
// - memory mode bit 1 marks more than 64K of display memory.
module vga_seq_regs #(
  parameter int ADDR_W = 10,
  parameter int CNT_W  = 4
) (
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  input  wire logic [ADDR_W-1:0] io_addr,
  input  wire logic              io_rd,
  input  wire logic              io_wr,
  input  wire logic [7:0]        io_wdata,
  output vga_seq_pkg::io_byte_t  io_rdata,
  input  wire logic              crtc_color_map,
  input  wire logic              frame_irq_pending,
  input  wire logic              monitor_sense,
  input  wire logic [7:0]        pixel_bits,
  input  wire logic [1:0]        plane_diag_sel,
  input  wire logic              vretrace_active,
  input  wire logic              display_off,
  input  wire logic              vsync_in,
  input  wire logic              vdisp_en,
  input  wire logic              mem_extended,
  input  wire logic              attr_font_bit,
  input  wire logic              dot_tick,
  output logic                   dot_en,
  output logic                   char_tick,
  output logic                   serial_load,
  output logic                   seq_halted,
  output logic                   vsync_out,
  output logic                   video_blank,
  output logic [3:0]             plane_wr_enable,
  output logic [2:0]             font_a_block,
  output logic [2:0]             font_b_block,
  output logic [2:0]             font_cur_block
);
  import vga_seq_pkg::*;

  generate
    if (ADDR_W < 10) begin : g_bad_addr
      $error("vga_seq_regs: ADDR_W must cover 10-bit I/O ports");
    end
  endgenerate

  // interleaved 8K blocks: value 1 sits in the 3rd block, 4 in the 2nd
  function automatic logic [2:0] font_block(input logic [2:0] sel);
    font_block = {sel[1:0], sel[2]};
  endfunction : font_block

  function automatic logic port_is(input logic [ADDR_W-1:0] addr,
                                   input logic [9:0]        port);
    port_is = (addr == ADDR_W'(port));
  endfunction : port_is

  seq_cfg_if cfg_bus ();

  // register state, reserved bits not stored
  logic [2:0] seq_index_pointer;
  logic [1:0] seq_halt_control;
  logic [5:0] seq_clock_config;
  logic [3:0] plane_write_mask;
  logic [5:0] font_location_select;
  logic       sync_gate_control;

  // address decode
  logic [9:0] status1_port;
  logic       hit_status0;
  logic       hit_index;
  logic       hit_data;
  logic       hit_feature_rd;
  logic       hit_status1;
  logic       wr_index;
  logic       wr_data;
  logic       wr_feature;
  logic [1:0] diag_bits;
  logic [7:0] status0_val;
  logic [7:0] status1_val;
  logic [7:0] seq_data_val;
  logic [7:0] next_rdata;
  logic [2:0] font_a_sel;
  logic [2:0] font_b_sel;

  assign status1_port   = crtc_color_map ? `PORT_STATUS1_COLOR
                                         : `PORT_STATUS1_MONO;
  assign hit_status0    = port_is(io_addr, `PORT_STATUS0);
  assign hit_index      = port_is(io_addr, `PORT_SEQ_INDEX);
  assign hit_data       = port_is(io_addr, `PORT_SEQ_DATA);
  assign hit_feature_rd = port_is(io_addr, `PORT_FEATURE_RD);
  assign hit_status1    = port_is(io_addr, status1_port);
  assign wr_index       = io_wr && hit_index;
  assign wr_data        = io_wr && hit_data;
  // status 1 port doubles as feature write; port 0 write has no target
  assign wr_feature     = io_wr && hit_status1;

  // colour plane diagnostic mux
  always_comb begin
    case (plane_diag_sel)
      2'b00:   diag_bits = {pixel_bits[2], pixel_bits[0]};
      2'b01:   diag_bits = {pixel_bits[5], pixel_bits[4]};
      2'b10:   diag_bits = {pixel_bits[3], pixel_bits[1]};
      2'b11:   diag_bits = {pixel_bits[7], pixel_bits[6]};
      default: diag_bits = 2'b00;
    endcase
  end

  always_comb begin
    status0_val = `READ_ZERO;
    status0_val[`ST0_IRQ_BIT]   = frame_irq_pending;
    status0_val[`ST0_SENSE_BIT] = monitor_sense;
  end

  always_comb begin
    status1_val = `READ_ZERO;
    status1_val[`ST1_DIAG_HI_BIT]  = diag_bits[1];
    status1_val[`ST1_DIAG_LO_BIT]  = diag_bits[0];
    status1_val[`ST1_VRETRACE_BIT] = vretrace_active;
    status1_val[`ST1_DISP_OFF_BIT] = display_off;
  end

  // sequencer data readback, reserved bits and unused indices read zero
  always_comb begin
    seq_data_val = `READ_ZERO;
    case (seq_index_pointer)
      `SEQ_IDX_HALT:    seq_data_val = {6'h00, seq_halt_control};
      `SEQ_IDX_CLOCK:   seq_data_val = {2'h0, seq_clock_config};
      `SEQ_IDX_MASK:    seq_data_val = {4'h0, plane_write_mask};
      `SEQ_IDX_FONT:    seq_data_val = {2'h0, font_location_select};
      `SEQ_IDX_MEMMODE: seq_data_val = {6'h00, mem_extended, 1'b0};
      default:          seq_data_val = `READ_ZERO;
    endcase
  end

  always_comb begin
    next_rdata = `READ_ZERO;
    if (hit_status0) begin
      next_rdata = status0_val;
    end else if (hit_status1) begin
      next_rdata = status1_val;
    end else if (hit_index) begin
      next_rdata = {5'h00, seq_index_pointer};
    end else if (hit_data) begin
      next_rdata = seq_data_val;
    end else if (hit_feature_rd) begin
      next_rdata = `READ_ZERO;
      next_rdata[`FC_VSYNC_OR_BIT] = sync_gate_control;
    end
  end

  // read data held until the next read so a slow host can sample it
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      io_rdata <= `READ_ZERO;
    end else if (io_rd) begin
      io_rdata <= next_rdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      seq_index_pointer <= `RST_INDEX;
    end else if (wr_index) begin
      seq_index_pointer <= io_wdata[2:0];
    end
  end

  // only defined bits are kept, so reserved-bit values are dropped
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      seq_halt_control <= `RST_HALT;
    end else if (wr_data && seq_index_pointer == `SEQ_IDX_HALT) begin
      seq_halt_control <= io_wdata[1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      seq_clock_config <= `RST_CLOCK;
    end else if (wr_data && seq_index_pointer == `SEQ_IDX_CLOCK) begin
      seq_clock_config <= io_wdata[5:0] & 6'h3d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      plane_write_mask <= `RST_MASK;
    end else if (wr_data && seq_index_pointer == `SEQ_IDX_MASK) begin
      plane_write_mask <= io_wdata[3:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      font_location_select <= `RST_FONT;
    end else if (wr_data && seq_index_pointer == `SEQ_IDX_FONT) begin
      font_location_select <= io_wdata[5:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sync_gate_control <= `RST_FEATURE;
    end else if (wr_feature) begin
      sync_gate_control <= io_wdata[`FC_VSYNC_OR_BIT];
    end
  end

  // configuration to the character clock generator
  assign cfg_bus.run_async  = seq_halt_control[`HALT_ASYNC_BIT];
  assign cfg_bus.run_sync   = seq_halt_control[`HALT_SYNC_BIT];
  assign cfg_bus.eight_dot  = seq_clock_config[`CLK_EIGHT_DOT_BIT];
  assign cfg_bus.shift_load = seq_clock_config[`CLK_SHIFT_LOAD_BIT];
  assign cfg_bus.dot_div2   = seq_clock_config[`CLK_DOT_DIV2_BIT];
  assign cfg_bus.shift4     = seq_clock_config[`CLK_SHIFT4_BIT];

  char_clock_gen #(
    .CNT_W (CNT_W)
  ) u_char_clock (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .dot_tick (dot_tick),
    .cfg      (cfg_bus.gen)
  );

  assign dot_en      = cfg_bus.dot_en;
  assign char_tick   = cfg_bus.char_tick;
  assign serial_load = cfg_bus.load_pulse;
  assign seq_halted  = cfg_bus.halted;

  // sync outputs stay alive under screen-off; only video is blanked
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      vsync_out <= 1'b0;
    end else begin
      vsync_out <= vsync_in || (sync_gate_control && vdisp_en);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      video_blank <= 1'b1;
    end else begin
      video_blank <= display_off || seq_clock_config[`CLK_SCREEN_OFF_BIT];
    end
  end

  assign plane_wr_enable = plane_write_mask;

  assign font_a_sel = {font_location_select[`FONT_A_HI_BIT],
                       font_location_select[`FONT_A_MID_BIT],
                       font_location_select[`FONT_A_LO_BIT]};
  assign font_b_sel = {font_location_select[`FONT_B_HI_BIT],
                       font_location_select[`FONT_B_MID_BIT],
                       font_location_select[`FONT_B_LO_BIT]};

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      font_a_block <= 3'h0;
      font_b_block <= 3'h0;
    end else begin
      font_a_block <= font_block(font_a_sel);
      font_b_block <= font_block(font_b_sel);
    end
  end

  // without extended memory the attribute bit keeps its colour meaning
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      font_cur_block <= 3'h0;
    end else if (mem_extended && !attr_font_bit) begin
      font_cur_block <= font_block(font_b_sel);
    end else begin
      font_cur_block <= font_block(font_a_sel);
    end
  end

endmodule : vga_seq_regs

`default_nettype wire

// *** sim/vga_seq_regs_checker.sv ***
/*
 * Concurrent checks on the register bank's top ports, bound below.
 * Assumes read data lands one cycle after the strobe edge.
 */
`timescale 1ns/10ps
`default_nettype none
`include "vga_seq_consts.svh"

module vga_seq_regs_checker #(
  parameter int ADDR_W = 10
) (
  input wire logic                 clk_sys,
  input wire logic                 sys_rst,
  input wire logic [ADDR_W-1:0]    io_addr,
  input wire logic                 io_rd,
  input wire logic                 io_wr,
  input wire logic [7:0]           io_wdata,
  input wire vga_seq_pkg::io_byte_t io_rdata,
  input wire logic                 crtc_color_map,
  input wire logic                 frame_irq_pending,
  input wire logic                 monitor_sense,
  input wire logic [7:0]           pixel_bits,
  input wire logic [1:0]           plane_diag_sel,
  input wire logic                 vretrace_active,
  input wire logic                 display_off,
  input wire logic                 vsync_in,
  input wire logic                 vdisp_en,
  input wire logic                 dot_en,
  input wire logic                 char_tick,
  input wire logic                 serial_load,
  input wire logic                 seq_halted,
  input wire logic                 vsync_out,
  input wire logic                 video_blank
);
  logic [ADDR_W-1:0] st0_port;
  logic [ADDR_W-1:0] st1_port;
  logic [1:0]        diag;
  logic              fc;

  assign st0_port = ADDR_W'(`PORT_STATUS0);
  assign st1_port = crtc_color_map ? ADDR_W'(`PORT_STATUS1_COLOR) : ADDR_W'(`PORT_STATUS1_MONO);

  always_comb begin
    case (plane_diag_sel)
      2'h0:    diag = {pixel_bits[2], pixel_bits[0]};
      2'h1:    diag = {pixel_bits[5], pixel_bits[4]};
      2'h2:    diag = {pixel_bits[3], pixel_bits[1]};
      default: diag = {pixel_bits[7], pixel_bits[6]};
    endcase
  end

  // shadow of the feature bit; only the mode-selected port stores it
  always_ff @(posedge clk_sys) begin
    if (sys_rst) fc <= 1'b0;
    else if (io_wr && io_addr == st1_port) fc <= io_wdata[`FC_VSYNC_OR_BIT];
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  property p_irq_bit;
    io_rd && io_addr == st0_port |=> io_rdata[7] == $past(frame_irq_pending);
  endproperty
  a_irq_bit: assert property (p_irq_bit) else $error("status 0 pending bit wrong");
  property p_sense_bit;
    io_rd && io_addr == st0_port |=> io_rdata[6:0] == {2'b00, $past(monitor_sense), 4'h0};
  endproperty
  a_sense_bit: assert property (p_sense_bit) else $error("status 0 sense field wrong");
  property p_diag;
    io_rd && io_addr == st1_port |=> io_rdata[5:4] == $past(diag);
  endproperty
  a_diag: assert property (p_diag) else $error("status 1 diagnostic bits wrong");
  property p_vretrace;
    io_rd && io_addr == st1_port |-> ##1 io_rdata[3] == $past(vretrace_active);
  endproperty
  a_vretrace: assert property (p_vretrace) else $error("status 1 retrace bit wrong");
  property p_disp_off;
    io_rd && io_addr == st1_port |=> io_rdata[2:0] == {2'b00, $past(display_off)};
  endproperty
  a_disp_off: assert property (p_disp_off) else $error("status 1 display bit wrong");
  property p_vsync_gate;
    !$past(sys_rst) |-> vsync_out == $past(vsync_in | (fc & vdisp_en));
  endproperty
  a_vsync_gate: assert property (p_vsync_gate) else $error("vertical sync output wrong");
  property p_blank;
    !$past(sys_rst) && $past(display_off) |-> video_blank;
  endproperty
  a_blank: assert property (p_blank) else $error("video not blanked");
  property p_halt_quiet;
    seq_halted |-> !(dot_en || char_tick || serial_load);
  endproperty
  a_halt_quiet: assert property (p_halt_quiet) else $error("strobe while halted");
  property p_load_on_char;
    serial_load |-> char_tick ##1 !char_tick [*7];
  endproperty
  a_load_on_char: assert property (p_load_on_char) else $error("load off a character");
endmodule : vga_seq_regs_checker

bind vga_seq_regs vga_seq_regs_checker #(.ADDR_W(ADDR_W)) u_chk (.*);

`default_nettype wire

// *** sim/host_io_model.sv ***
/*
 * Host processor on the I/O bus: single-strobe port reads and writes,
 * plus indexed sequencer access. Assumes strobes sampled on rising clk_sys.
 */
`timescale 1ns/10ps
`default_nettype none
`include "vga_seq_consts.svh"

module host_io_model (
  input  wire logic                  clk_sys,
  output logic [9:0]                 io_addr,
  output logic                       io_rd,
  output logic                       io_wr,
  output logic [7:0]                 io_wdata,
  input  wire vga_seq_pkg::io_byte_t io_rdata
);
  initial begin
    io_addr = '0;
    io_rd = 1'b0;
    io_wr = 1'b0;
    io_wdata = '0;
  end

  // released lines show the inverse so stale values never pass for live ones
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    {io_addr, io_wdata, io_wr} = {a, d, 1'b1};
    @(negedge clk_sys);
    {io_addr, io_wdata, io_wr} = {~a, ~d, 1'b0};
  endtask : wr

  task automatic rd(input logic [9:0] a, output logic [7:0] v);
    @(negedge clk_sys);
    {io_addr, io_rd} = {a, 1'b1};
    @(negedge clk_sys);
    {io_addr, io_rd} = {~a, 1'b0};
    v = io_rdata;
  endtask : rd

  task automatic swr(input logic [2:0] idx, input logic [7:0] d);
    wr(`PORT_SEQ_INDEX, {5'h00, idx});
    wr(`PORT_SEQ_DATA, d);
  endtask : swr

  task automatic srd(input logic [2:0] idx, output logic [7:0] v);
    wr(`PORT_SEQ_INDEX, {5'h00, idx});
    rd(`PORT_SEQ_DATA, v);
  endtask : srd
endmodule : host_io_model

`default_nettype wire

// *** sim/testbench.sv ***
/*
 * Self-checking bench for the status and sequencer register bank.
 * Assumes the host model and checker compiled before it.
 */
`timescale 1ns/10ps
`default_nettype none
`include "vga_seq_consts.svh"

module testbench;
  import vga_seq_pkg::*;
  logic clk_sys, sys_rst, crtc_color_map, frame_irq_pending, monitor_sense, vretrace_active;
  logic display_off, vsync_in, vdisp_en, mem_extended, attr_font_bit, dot_tick, io_rd, io_wr;
  logic dot_en, char_tick, serial_load, seq_halted, vsync_out, video_blank;
  logic [7:0] pixel_bits, io_wdata, d;
  logic [1:0] plane_diag_sel;
  logic [9:0] io_addr, st1;
  logic [3:0] plane_wr_enable;
  logic [2:0] font_a_block, font_b_block, font_cur_block, idx, fa, fb;
  io_byte_t   io_rdata, rd_v;
  logic [7:0] sh[4] = '{8'h03, 8'h00, 8'h0f, 8'h00};
  logic [7:0] fmask[4] = '{8'h03, 8'h3d, 8'h0f, 8'h3f};
  logic [7:0] rst_t[6] = '{8'h03, 8'h00, 8'h0f, 8'h00, 8'h02, 8'h00};
  logic [7:0] cfg_t[5] = '{8'h00, 8'h04, 8'h14, 8'h01, 8'h08};
  int chr_t[5] = '{8, 8, 8, 9, 4};
  int ld_t[5] = '{8, 4, 2, 9, 4};
  int error_cnt = 0, cmp_count = 0, n_char, n_load, n_dot;

  vga_seq_regs u_vga_seq_regs (.*);

  host_io_model u_host_io_model (.clk_sys(clk_sys), .io_addr(io_addr), .io_rd(io_rd),
    .io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(io_rdata));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s saw %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic conclude();
    $display("errors %0d comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  // font blocks interleave: value bit 2 picks the odd 8K block
  function automatic logic [2:0] blk(input logic [2:0] v);
    return {v[1:0], v[2]};
  endfunction : blk

  function automatic logic [1:0] diag_f(input logic [7:0] p, input logic [1:0] s);
    case (s)
      2'h0: return {p[2], p[0]};
      2'h1: return {p[5], p[4]};
      2'h2: return {p[3], p[1]};
      default: return {p[7], p[6]};
    endcase
  endfunction : diag_f

  task automatic count(input int cycles);
    n_char = 0;
    n_load = 0;
    n_dot = 0;
    repeat (cycles) begin
      @(negedge clk_sys);
      n_dot += int'(dot_en);
      n_char += int'(char_tick);
      n_load += int'(serial_load);
    end
  endtask : count

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    conclude();
  end

  initial begin
    sys_rst = 1'b1;
    {crtc_color_map, frame_irq_pending, monitor_sense, vretrace_active, display_off} = '0;
    {vsync_in, vdisp_en, attr_font_bit, pixel_bits, plane_diag_sel} = '0;
    mem_extended = 1'b1;
    dot_tick = 1'b1;
    void'($urandom(24881));
    repeat (8) @(negedge clk_sys);
    sys_rst = 1'b0;
    for (int i = 0; i < 6; i++) begin
      u_host_io_model.srd(3'(i), rd_v);
      check(rd_v, rst_t[i], "reset value");
    end
    u_host_io_model.rd(10'h3c0, rd_v);
    check(rd_v, 8'h00, "unmapped");
    for (int i = 0; i < 12; i++) begin
      idx = 3'($urandom_range(3, 1));
      d = 8'($urandom) & fmask[idx];
      sh[idx] = d;
      {mem_extended, attr_font_bit} = 2'($urandom);
      u_host_io_model.swr(idx, d);
      u_host_io_model.srd(idx, rd_v);
      fa = blk({sh[3][5], sh[3][3:2]});
      fb = blk({sh[3][4], sh[3][1:0]});
      check(rd_v, d, "readback");
      check(8'(plane_wr_enable), 8'(sh[2][3:0]), "mask");
      check(8'(font_a_block), 8'(fa), "font a");
      check(8'(font_b_block), 8'(fb), "font b");
      check(8'(font_cur_block), 8'((mem_extended && !attr_font_bit) ? fb : fa), "font cur");
    end
    for (int i = 0; i < 8; i++) begin
      {frame_irq_pending, monitor_sense, crtc_color_map} = 3'($urandom);
      display_off = 1'b0;
      pixel_bits = 8'($urandom);
      plane_diag_sel = 2'(i);
      st1 = crtc_color_map ? `PORT_STATUS1_COLOR : `PORT_STATUS1_MONO;
      u_host_io_model.wr(`PORT_STATUS0, 8'($urandom));
      u_host_io_model.rd(`PORT_STATUS0, rd_v);
      check(rd_v, {frame_irq_pending, 2'b00, monitor_sense, 4'h0}, "status 0");
      {vretrace_active, display_off} = 2'($urandom);
      u_host_io_model.rd(st1, rd_v);
      d = {2'b00, diag_f(pixel_bits, plane_diag_sel), vretrace_active, 2'b00, display_off};
      check(rd_v, d, "status 1");
    end
    {crtc_color_map, vsync_in, vdisp_en, display_off} = 4'b1010;
    u_host_io_model.wr(`PORT_STATUS1_MONO, 8'h08);
    u_host_io_model.rd(`PORT_FEATURE_RD, rd_v);
    check(rd_v, 8'h00, "wrong port");
    u_host_io_model.wr(`PORT_STATUS1_COLOR, 8'hff);
    u_host_io_model.rd(`PORT_FEATURE_RD, rd_v);
    check(rd_v, 8'h08, "feature");
    check(8'(vsync_out), 8'h01, "vsync or");
    u_host_io_model.wr(`PORT_STATUS1_COLOR, 8'h00);
    @(negedge clk_sys);
    check(8'(vsync_out), 8'h00, "vsync");
    for (int i = 0; i < 5; i++) begin
      u_host_io_model.swr(3'h1, cfg_t[i]);
      repeat (20) @(negedge clk_sys);
      count(72);
      check(8'(n_dot), cfg_t[i][3] ? 8'h24 : 8'h48, "dots");
      check(8'(n_char), 8'(chr_t[i]), "ticks");
      check(8'(n_load), 8'(ld_t[i]), "loads");
    end
    u_host_io_model.swr(3'h1, 8'h00);
    u_host_io_model.swr(3'h0, 8'h02);
    check(8'(seq_halted), 8'h01, "async halt");
    count(20);
    check(8'(n_char), 8'h00, "halted ticks");
    u_host_io_model.swr(3'h0, 8'h03);
    count(36);
    check(8'(n_char > 2), 8'h01, "restart");
    u_host_io_model.swr(3'h0, 8'h01);
    repeat (10) @(negedge clk_sys);
    check(8'(seq_halted), 8'h01, "sync halt");
    count(20);
    check(8'(n_char), 8'h00, "sync ticks");
    u_host_io_model.swr(3'h0, 8'h03);
    vsync_in = 1'b1;
    u_host_io_model.swr(3'h1, 8'h20);
    @(negedge clk_sys);
    check(8'({video_blank, vsync_out}), 8'h03, "screen off");
    u_host_io_model.swr(3'h1, 8'h00);
    @(negedge clk_sys);
    check(8'(video_blank), 8'h00, "screen on");
    conclude();
  end
endmodule : testbench

`default_nettype wire
